/* File: logic/pll_clock_config_pkg.sv */
// Package: register map, field layout and reset values of the loop clock control.
// Assumes a 16-bit register port clocked by the converter input clock.
package pll_clock_config_pkg;

    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 16;

    // Register indices
    localparam logic [7:0]  POWER_CONTROL_ADDR   = 8'h1a;
    localparam logic [7:0]  LOOP_CONTROL_ADDR    = 8'h31;
    localparam logic [7:0]  DIVIDER_SETTING_ADDR = 8'h32;
    localparam logic [7:0]  VCO_TUNE_ADDR        = 8'h33;
    localparam logic [7:0]  LOOP_STATUS_ADDR     = 8'h34;

    // Field positions
    localparam int          SLEEP_BIT       = 0;
    localparam int          PATH_BIT        = 0;
    localparam int          CP_LSB          = 8;
    localparam int          P_LSB           = 0;
    localparam int          N_LSB           = 4;
    localparam int          M_LSB           = 8;
    localparam int          VCO_LSB         = 0;
    localparam int          ITUNE_LSB       = 8;
    localparam int          BAND_BIT        = 10;
    localparam int          N_MSB_BIT       = 1;

    // Reset values: bypass with loop asleep
    localparam logic [15:0] POWER_CONTROL_RST   = 16'h0001;
    localparam logic [15:0] LOOP_CONTROL_RST    = 16'h0000;
    localparam logic [15:0] DIVIDER_SETTING_RST = 16'h0000;
    localparam logic [15:0] VCO_TUNE_RST        = 16'h0000;
    localparam logic [15:0] BUS_ZERO            = 16'h0000;

    typedef enum logic [1:0] {
        MODE_BYPASS,
        MODE_LOOP,
        MODE_MIXED
    } clock_mode_e;

    // Settings handed to the analog loop
    typedef struct packed {
        logic       loop_path_select;
        logic       loop_sleep;
        logic       vco_band_low;
        logic [5:0] vco_coarse_tune;
        logic [1:0] vco_current_tune;
        logic [3:0] prescaler_code;
        logic [4:0] ref_divider_code;
        logic [7:0] feedback_divider_code;
        logic [4:0] charge_pump_current_code;
    } loop_config_s;

endpackage : pll_clock_config_pkg

/* File: logic/pll_clock_config_control.sv */
// Holds the loop clock configuration registers and drives the loop settings.
// Assumes register strobes are one cycle and synchronous to i_clock.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module pll_clock_config_control
    import pll_clock_config_pkg::*;
(
    input  wire logic                                    i_clock,
    input  wire logic                                    i_srst,
    input  wire logic [pll_clock_config_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [pll_clock_config_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                                    i_write,
    input  wire logic                                    i_read,
    output logic [pll_clock_config_pkg::DATA_W-1:0]      o_rdata,
    output pll_clock_config_pkg::loop_config_s           o_loop_config,
    output logic                                         o_bypass_active,
    output logic                                         o_loop_active,
    output logic [8:0]                                   o_loop_ratio
);
    import pll_clock_config_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic hit(
        input logic [7:0] a,
        input logic [7:0] r
    );
        hit = (a == r);
    endfunction : hit

    // Prescaler ratio for listed codes, zero where undefined
    function automatic logic [4:0] prescale_ratio(
        input logic [3:0] c
    );
        case (c)
            4'h0:    prescale_ratio = 5'h02;
            4'h1:    prescale_ratio = 5'h03;
            4'h2:    prescale_ratio = 5'h04;
            4'h3:    prescale_ratio = 5'h05;
            4'h5:    prescale_ratio = 5'h07;
            4'h6:    prescale_ratio = 5'h08;
            4'h7:    prescale_ratio = 5'h0a;
            default: prescale_ratio = 5'h00;
        endcase
    endfunction : prescale_ratio

    // Clock mode from path and sleep bits
    function automatic clock_mode_e mode_of(
        input logic path,
        input logic sleep
    );
        if (!path && sleep)
            mode_of = MODE_BYPASS;
        else if (path && !sleep)
            mode_of = MODE_LOOP;
        else
            mode_of = MODE_MIXED;
    endfunction : mode_of

    // P times (M field + 1), saturated into status width
    function automatic logic [8:0] loop_ratio_of(
        input logic [3:0] p,
        input logic [7:0] m
    );
        logic [12:0] full;
        full = 13'(prescale_ratio(p)) * (13'(m) + 13'h0001);
        loop_ratio_of = (full > 13'h01ff) ? 9'h1ff : full[8:0];
    endfunction : loop_ratio_of

    // Settings word from the four configuration registers
    function automatic loop_config_s settings_of(
        input logic [15:0] power_control,
        input logic [15:0] loop_control,
        input logic [15:0] divider_setting,
        input logic [15:0] vco_tune
    );
        settings_of.loop_path_select         = loop_control[PATH_BIT];
        settings_of.loop_sleep               = power_control[SLEEP_BIT];
        settings_of.vco_band_low             = vco_tune[BAND_BIT];
        settings_of.vco_coarse_tune          = vco_tune[VCO_LSB +: 6];
        settings_of.vco_current_tune         = vco_tune[ITUNE_LSB +: 2];
        settings_of.prescaler_code           = divider_setting[P_LSB +: 4];
        settings_of.ref_divider_code         = {loop_control[N_MSB_BIT],
                                                divider_setting[N_LSB +: 4]};
        settings_of.feedback_divider_code    = divider_setting[M_LSB +: 8];
        settings_of.charge_pump_current_code = power_control[CP_LSB +: 5];
    endfunction : settings_of

    // Status word: mode above the loop ratio
    function automatic logic [15:0] status_of(
        input clock_mode_e m,
        input logic [8:0]  r
    );
        status_of = {5'h00, m, r};
    endfunction : status_of

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [15:0]  power_control_reg;
    logic [15:0]  loop_control_reg;
    logic [15:0]  divider_setting_reg;
    logic [15:0]  vco_tune_reg;
    logic [15:0]  next_power_control_reg;
    logic [15:0]  next_loop_control_reg;
    logic [15:0]  next_divider_setting_reg;
    logic [15:0]  next_vco_tune_reg;
    logic [15:0]  next_rdata;
    loop_config_s next_loop_config;
    clock_mode_e  mode;
    clock_mode_e  next_mode;
    logic [8:0]   loop_ratio;
    logic [8:0]   next_loop_ratio;

    ////////////////////////////////////////////////////////////////////////
    // Power control register
    always_comb
    begin
        next_power_control_reg = power_control_reg;
        if (i_write && hit(i_addr, POWER_CONTROL_ADDR))
            next_power_control_reg = i_wdata;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            power_control_reg <= POWER_CONTROL_RST;
        else
            power_control_reg <= next_power_control_reg;
    end

    // Loop control register
    always_comb
    begin
        next_loop_control_reg = loop_control_reg;
        if (i_write && hit(i_addr, LOOP_CONTROL_ADDR))
            next_loop_control_reg = i_wdata;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            loop_control_reg <= LOOP_CONTROL_RST;
        else
            loop_control_reg <= next_loop_control_reg;
    end

    // Divider setting register
    always_comb
    begin
        next_divider_setting_reg = divider_setting_reg;
        if (i_write && hit(i_addr, DIVIDER_SETTING_ADDR))
            next_divider_setting_reg = i_wdata;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            divider_setting_reg <= DIVIDER_SETTING_RST;
        else
            divider_setting_reg <= next_divider_setting_reg;
    end

    // VCO tune register
    always_comb
    begin
        next_vco_tune_reg = vco_tune_reg;
        if (i_write && hit(i_addr, VCO_TUNE_ADDR))
            next_vco_tune_reg = i_wdata;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            vco_tune_reg <= VCO_TUNE_RST;
        else
            vco_tune_reg <= next_vco_tune_reg;
    end

    // Read mux, zero when idle or unmapped
    always_comb
    begin
        next_rdata = BUS_ZERO;
        if (i_read)
        begin
            if (hit(i_addr, POWER_CONTROL_ADDR))
                next_rdata = power_control_reg;
            else if (hit(i_addr, LOOP_CONTROL_ADDR))
                next_rdata = loop_control_reg;
            else if (hit(i_addr, DIVIDER_SETTING_ADDR))
                next_rdata = divider_setting_reg;
            else if (hit(i_addr, VCO_TUNE_ADDR))
                next_rdata = vco_tune_reg;
            else if (hit(i_addr, LOOP_STATUS_ADDR))
                next_rdata = status_of(mode, loop_ratio);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop settings and mode, new values apply at the write edge
    always_comb
    begin
        next_loop_config = settings_of(next_power_control_reg,
                                       next_loop_control_reg,
                                       next_divider_setting_reg,
                                       next_vco_tune_reg);
        next_mode        = mode_of(next_loop_config.loop_path_select,
                                   next_loop_config.loop_sleep);
        next_loop_ratio  = loop_ratio_of(next_loop_config.prescaler_code,
                                         next_loop_config.feedback_divider_code);
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            mode       <= MODE_BYPASS;
            loop_ratio <= 9'h000;
        end
        else
        begin
            mode       <= next_mode;
            loop_ratio <= next_loop_ratio;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // Read data, one cycle after the strobe
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_rdata <= BUS_ZERO;
        end
        else
        begin
            o_rdata <= next_rdata;
        end
    end

    // Settings to the analog loop
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_loop_config <= '0;
        end
        else
        begin
            o_loop_config <= next_loop_config;
        end
    end

    // Bypass flag
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_bypass_active <= 1'b0;
        end
        else
        begin
            o_bypass_active <= (next_mode == MODE_BYPASS);
        end
    end

    // Loop flag
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_loop_active <= 1'b0;
        end
        else
        begin
            o_loop_active <= (next_mode == MODE_LOOP);
        end
    end

    // Total loop ratio
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_loop_ratio <= 9'h000;
        end
        else
        begin
            o_loop_ratio <= next_loop_ratio;
        end
    end

endmodule : pll_clock_config_control

/* File: tb/pll_loop_model.sv */
// Behavioural analog loop: decodes the settings into the core clock source.
// Assumes settings straight from pll_clock_config_control.
`timescale 1ns/1ps
module pll_loop_model (
    input  wire pll_clock_config_pkg::loop_config_s i_loop_config,
    output logic                                    o_core_from_loop,
    output logic                                    o_vco_running
);
    import pll_clock_config_pkg::*;
    assign o_vco_running    = !i_loop_config.loop_sleep;
    assign o_core_from_loop = i_loop_config.loop_path_select && o_vco_running;
endmodule : pll_loop_model

/* File: tb/pll_clock_config_sva.sv */
// Port checker for the loop clock control.
// Assumes binding to every pll_clock_config_control instance.
`timescale 1ns/1ps
module pll_clock_config_sva (
    input wire logic                                i_clock,
    input wire logic                                i_srst,
    input wire logic [7:0]                          i_addr,
    input wire logic [15:0]                         i_wdata,
    input wire logic                                i_write,
    input wire logic                                i_read,
    input wire logic [15:0]                         o_rdata,
    input wire pll_clock_config_pkg::loop_config_s  o_loop_config,
    input wire logic                                o_bypass_active,
    input wire logic                                o_loop_active,
    input wire logic [8:0]                          o_loop_ratio
);
    import pll_clock_config_pkg::*;
    logic         live;
    loop_config_s c;
    assign c = o_loop_config;
    always_ff @(posedge i_clock) live <= !i_srst;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_byp; live |-> o_bypass_active == (!c.loop_path_select && c.loop_sleep); endproperty
    a_byp: assert property (p_byp) else $error("bypass flag wrong");
    property p_loop; live |-> o_loop_active == (c.loop_path_select && !c.loop_sleep); endproperty
    a_loop: assert property (p_loop) else $error("loop flag wrong");
    property p_path; i_write && i_addr == LOOP_CONTROL_ADDR
        |=> {c.loop_path_select, c.ref_divider_code[4]} == $past({i_wdata[0], i_wdata[1]});
    endproperty
    a_path: assert property (p_path) else $error("path write lost");
    property p_pwr; i_write && i_addr == POWER_CONTROL_ADDR
        |=> {c.loop_sleep, c.charge_pump_current_code} == $past({i_wdata[0], i_wdata[12:8]});
    endproperty
    a_pwr: assert property (p_pwr) else $error("power write lost");
    property p_div; i_write && i_addr == DIVIDER_SETTING_ADDR
        |=> {c.feedback_divider_code, c.ref_divider_code[3:0], c.prescaler_code} == $past(i_wdata);
    endproperty
    a_div: assert property (p_div) else $error("divider write lost");
    property p_vco; i_write && i_addr == VCO_TUNE_ADDR |=> {c.vco_band_low, c.vco_current_tune,
        c.vco_coarse_tune} == $past({i_wdata[10:8], i_wdata[5:0]});
    endproperty
    a_vco: assert property (p_vco) else $error("tune write lost");
    property p_hold; live && !i_write |=> $stable(o_loop_config); endproperty
    a_hold: assert property (p_hold) else $error("settings moved");
    property p_stat; i_read && i_addr == LOOP_STATUS_ADDR |=> o_rdata ==
        {5'h0, $past({!o_bypass_active && !o_loop_active, o_loop_active, o_loop_ratio})};
    endproperty
    a_stat: assert property (p_stat) else $error("status wrong");
    c_loop: cover property (o_loop_active);
    c_back: cover property ($rose(o_bypass_active) && live);
    c_stat: cover property (i_read && i_addr == LOOP_STATUS_ADDR);
endmodule : pll_clock_config_sva
bind pll_clock_config_control pll_clock_config_sva pll_clock_config_sva_inst (
    .i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .o_loop_config(o_loop_config),
    .o_bypass_active(o_bypass_active), .o_loop_active(o_loop_active),
    .o_loop_ratio(o_loop_ratio));

/* File: tb/tb_pll_clock_config_control.sv */
// Self-checking bench for the loop clock control.
// Assumes the bound checker and the loop model.
`timescale 1ns/1ps
module tb_pll_clock_config_control;
    import pll_clock_config_pkg::*;
    logic         i_clock = 1'b0;
    logic         i_srst = 1'b1;
    logic [7:0]   i_addr = 8'h0;
    logic [15:0]  i_wdata = 16'h0;
    logic         i_write = 1'b0;
    logic         i_read = 1'b0;
    logic [15:0]  o_rdata, d, r;
    loop_config_s o_loop_config;
    logic         o_bypass_active, o_loop_active, from_loop, vco_on;
    logic [8:0]   o_loop_ratio;
    logic [7:0]   m;
    int           n_fail = 0;
    int           checks_done = 0;
    int           cycles = 0;
    pll_clock_config_control pll_clock_config_control_inst (.i_clock(i_clock),
        .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .o_rdata(o_rdata), .o_loop_config(o_loop_config),
        .o_bypass_active(o_bypass_active), .o_loop_active(o_loop_active),
        .o_loop_ratio(o_loop_ratio));
    pll_loop_model pll_loop_model_inst (.i_loop_config(o_loop_config),
        .o_core_from_loop(from_loop), .o_vco_running(vco_on));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] exp_ratio(logic [3:0] p, logic [7:0] m);
        logic [12:0] t;
        t = 13'(m) + 13'h1;
        case (p)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6: t = t * (13'(p) + 13'h2);
            4'h7: t = t * 13'ha;
            default: t = 13'h0;
        endcase
        return (t > 13'h1ff) ? 9'h1ff : t[8:0];
    endfunction : exp_ratio
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= v;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        v = o_rdata;
    endtask : rd
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #20 i_clock = ~i_clock;
    always @(posedge i_clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_fail++;
            stop_test();
        end
    end
    initial
    begin
        d = $urandom(19860);
        repeat (3) @(posedge i_clock);
        i_srst <= 1'b0;
        repeat (2) @(posedge i_clock);
        #1;
        chk({o_bypass_active, o_loop_ratio}, 16'h0202);
        rd(LOOP_STATUS_ADDR, r);
        chk(r, 16'h0002);
        $display("test reset done");
        wr(LOOP_CONTROL_ADDR, 16'h0001);
        chk({o_bypass_active, o_loop_active}, 16'h0000);
        wr(POWER_CONTROL_ADDR, {3'h0, d[4:0], 8'h00});
        chk({o_loop_active, from_loop, o_loop_config.charge_pump_current_code}, {2'h3, d[4:0]});
        rd(LOOP_STATUS_ADDR, r);
        chk(r[10:9], 16'h0001);
        $display("test loop done");
        for (int p = 0; p < 16; p++)
        begin
            m = (p == 7) ? 8'hff : 8'($urandom);
            d = 16'($urandom);
            wr(LOOP_CONTROL_ADDR, {14'h0, d[4], 1'b1});
            wr(DIVIDER_SETTING_ADDR, {m, d[3:0], 4'(p)});
            chk(o_loop_ratio, exp_ratio(4'(p), m));
            chk({o_loop_config.prescaler_code, o_loop_config.ref_divider_code}, {4'(p), d[4:0]});
            rd(DIVIDER_SETTING_ADDR, r);
            chk(r, {m, d[3:0], 4'(p)});
        end
        wr(DIVIDER_SETTING_ADDR, {8'h0b, 4'h0, 4'h7});
        chk(o_loop_ratio, exp_ratio(4'h7, 8'h0b));
        wr(POWER_CONTROL_ADDR, {3'h0, 5'h18, 8'h00});
        chk({o_loop_active, o_loop_config.charge_pump_current_code}, 16'h0038);
        $display("test dividers done");
        repeat (4)
        begin
            d = 16'($urandom);
            wr(VCO_TUNE_ADDR, d);
            chk({o_loop_config.vco_band_low, o_loop_config.vco_current_tune,
                o_loop_config.vco_coarse_tune}, {d[10:8], d[5:0]});
        end
        wr(VCO_TUNE_ADDR, {5'h0, 1'b0, 2'h3, 2'h0, 6'h21});
        chk({o_loop_config.vco_band_low, o_loop_config.vco_current_tune}, 16'h0003);
        wr(VCO_TUNE_ADDR, {5'h0, 1'b1, 2'h2, 2'h0, 6'h1f});
        chk({o_loop_config.vco_band_low, o_loop_config.vco_coarse_tune}, 16'h005f);
        $display("test tuning done");
        wr(8'h77, 16'hffff);
        rd(8'h77, r);
        chk({r, o_loop_config.loop_path_select}, 17'h00001);
        wr(LOOP_CONTROL_ADDR, 16'h0000);
        wr(POWER_CONTROL_ADDR, 16'h0001);
        chk({o_bypass_active, vco_on, from_loop}, 16'h0004);
        $display("test bypass done");
        stop_test();
    end
endmodule : tb_pll_clock_config_control
